// file: logic/ephy_cfg.svh
// constants for the transceiver control block
`ifndef EPHY_CFG_SVH
`define EPHY_CFG_SVH
`define EPHY_IDLE_GRP  5'h1F
`define EPHY_J_GRP     5'h18
`define EPHY_K_GRP     5'h11
`define EPHY_T_GRP     5'h0D
`define EPHY_R_GRP     5'h07
`define EPHY_PRE_NIB   4'h5
`define EPHY_BAD_NIB   4'hE
`define EPHY_CLK_NS    10
`define EPHY_LINKUP_NS 395000
`define EPHY_SQWIN_NS  150
`define EPHY_LPPER_NS  16000000
`define EPHY_LPW_NS    100
`define EPHY_JAB_NS    85000000
`define EPHY_UNJAB_NS  500000000
`define EPHY_LOSS_NS   100000000
`define EPHY_HBDLY_NS  1000
`define EPHY_HBW_NS    1000
`define EPHY_SQWIN_CYC (`EPHY_SQWIN_NS / `EPHY_CLK_NS)
`define EPHY_LPW_CYC   (`EPHY_LPW_NS / `EPHY_CLK_NS)
`define EPHY_HBDLY_CYC (`EPHY_HBDLY_NS / `EPHY_CLK_NS)
`define EPHY_HBW_CYC   (`EPHY_HBW_NS / `EPHY_CLK_NS)
`endif

// file: logic/ephy_pkg.sv
// types and the 5B to 4B lookup for the transceiver control block
package ephy_pkg;
    typedef enum logic [1:0] {ST_HUNT, ST_JCHK, ST_DATA, ST_BAD} ephy_rx_t;
    typedef enum logic [1:0] {SQ_IDLE, SQ_OPP, SQ_ORIG, SQ_VALID} ephy_sq_t;

    // returns {invalid, nibble}
    function automatic logic [4:0] ephy_dec(input logic [4:0] c);
        case (c)
            5'h1E: ephy_dec = 5'h00;
            5'h09: ephy_dec = 5'h01;
            5'h14: ephy_dec = 5'h02;
            5'h15: ephy_dec = 5'h03;
            5'h0A: ephy_dec = 5'h04;
            5'h0B: ephy_dec = 5'h05;
            5'h0E: ephy_dec = 5'h06;
            5'h0F: ephy_dec = 5'h07;
            5'h12: ephy_dec = 5'h08;
            5'h13: ephy_dec = 5'h09;
            5'h16: ephy_dec = 5'h0A;
            5'h17: ephy_dec = 5'h0B;
            5'h1A: ephy_dec = 5'h0C;
            5'h1B: ephy_dec = 5'h0D;
            5'h1C: ephy_dec = 5'h0E;
            5'h1D: ephy_dec = 5'h0F;
            default: ephy_dec = 5'h1E;
        endcase
    endfunction
endpackage

// file: logic/ephy_cnt.sv
// saturating cycle counter with synchronous clear
`timescale 1ns/1ps
module ephy_cnt
    import ephy_pkg::*;
#(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst_b,
    input  wire logic         clkEn,
    // control
    input  wire logic         clr,
    output logic      [W-1:0] count
);
    logic [W-1:0] count_q;

    assign count = count_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            count_q <= '0;
        end else if (clkEn) begin
            if (clr) begin
                count_q <= '0;
            end else if (count_q != '1) begin
                count_q <= count_q + W'(1);
            end
        end
    end

    a_cnt_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clkEn && clr |=> count_q == '0)
        else $error("counter not cleared");
endmodule

// file: logic/ephy_align.sv
// 5B code-group aligner that locks on the start pair
`timescale 1ns/1ps
`include "ephy_cfg.svh"
module ephy_align
    import ephy_pkg::*;
(
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic       clkEn,
    // unaligned symbols
    input  wire logic       symValid,
    input  wire logic       descrBypass,
    input  wire logic [4:0] descrBits,
    input  wire logic [4:0] rawBits,
    input  wire logic       hunt,
    // aligned groups
    output logic      [4:0] grp,
    output logic            grpValid,
    output logic            jkHit
);
    logic [4:0] w1_q;
    logic [4:0] w2_q;
    logic [4:0] grp_q;
    logic [2:0] off_q;
    logic       grpValid_q;
    logic       jkHit_q;
    logic [4:0] hit;
    logic [2:0] hitOff;

    wire [4:0]  inBits = descrBypass ? rawBits : descrBits;
    wire [14:0] s15    = {w2_q, w1_q, inBits};
    wire [9:0]  s10    = {w1_q, inBits};
    wire        hitAny = hunt && (hit != 5'h00);
    wire [2:0]  offUse = hitAny ? hitOff : off_q;

    genvar k;
    generate
        for (k = 0; k < 5; k++) begin : g_hit
            assign hit[k] = s15[14-k -: 10] == {`EPHY_J_GRP, `EPHY_K_GRP};
        end
    endgenerate

    always_comb begin
        hitOff = 3'h0;
        for (int i = 4; i >= 0; i--) begin
            if (hit[i]) begin
                hitOff = 3'(i);
            end
        end
    end

    assign grp      = grp_q;
    assign grpValid = grpValid_q;
    assign jkHit    = jkHit_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            w1_q       <= 5'h00;
            w2_q       <= 5'h00;
            grp_q      <= 5'h00;
            off_q      <= 3'h0;
            grpValid_q <= 1'b0;
            jkHit_q    <= 1'b0;
        end else if (clkEn) begin
            grpValid_q <= symValid;
            jkHit_q    <= symValid && hitAny;
            if (symValid) begin
                w2_q  <= w1_q;
                w1_q  <= inBits;
                off_q <= offUse;
                grp_q <= s10[9-offUse -: 5];
            end
        end
    end

    a_jk_lock: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        clkEn && symValid && hitAny
        |=> off_q == $past(hitOff) && jkHit_q)
        else $error("aligner did not lock on start pair");
endmodule

// file: logic/ephy_ctrl.sv
// transceiver control: 100M receive PCS and 10BASE-T link functions
`timescale 1ns/1ps
`include "ephy_cfg.svh"
module ephy_ctrl
    import ephy_pkg::*;
#(
    parameter int LINKUP_CYC = (`EPHY_LINKUP_NS + `EPHY_CLK_NS - 1)
                               / `EPHY_CLK_NS,
    parameter int LPPER_CYC  = `EPHY_LPPER_NS / `EPHY_CLK_NS,
    parameter int JAB_CYC    = `EPHY_JAB_NS / `EPHY_CLK_NS,
    parameter int UNJAB_CYC  = `EPHY_UNJAB_NS / `EPHY_CLK_NS,
    parameter int LOSS_CYC   = `EPHY_LOSS_NS / `EPHY_CLK_NS
) (
    // clock, reset, enable
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        clkEn,
    // mode
    input  wire logic        speed100,
    input  wire logic        fullDuplex,
    input  wire logic        heartbeat_disable,
    input  wire logic        forceLink10,
    input  wire logic        descrBypass,
    // 100M line side
    input  wire logic        sigDetect,
    input  wire logic        symValid,
    input  wire logic [4:0]  descrBits,
    input  wire logic [4:0]  rawBits,
    // 10M line side
    input  wire logic        sqPos,
    input  wire logic        sqNeg,
    input  wire logic        linkPulseIn,
    // MAC transmit
    input  wire logic        txEnMii,
    // MII receive status
    output logic      [3:0]  rxd,
    output logic             rxDv,
    output logic             rxEr,
    output logic             crs,
    output logic             col,
    // status
    output logic             linkUp100,
    output logic             linkGood10,
    output logic             txEnable10,
    output logic             linkPulseOut,
    output logic             jabber,
    output logic      [15:0] false_carrier_count_reg
);
    ephy_rx_t    st_q;
    ephy_rx_t    st_d;
    ephy_sq_t    sq_q;
    ephy_sq_t    sq_d;
    logic [3:0]  rxd_q;
    logic [3:0]  hold_q;
    logic        rxDv_q;
    logic        rxEr_q;
    logic        crs_q;
    logic        col_q;
    logic        tSeen_q;
    logic [1:0]  idle_q;
    logic [15:0] fcc_q;
    logic        linkUp_q;
    logic        linkSeen_q;
    logic        txEn10_q;
    logic        lpOut_q;
    logic        jab_q;
    logic        hb_q;
    logic        txPrev_q;
    logic        firstPos_q;
    logic [4:0]  grp;
    logic        grpValid;
    logic        jkHit;
    logic [15:0] luCnt;
    logic [20:0] lpCnt;
    logic [23:0] jabCnt;
    logic [25:0] unjabCnt;
    logic [23:0] lossCnt;
    logic [5:0]  sqCnt;
    logic [7:0]  hbCnt;
    logic        sqClr;

    wire pcsOn   = linkUp_q && speed100;
    wire g       = clkEn && grpValid && pcsOn;
    wire isIdle  = grp == `EPHY_IDLE_GRP;
    wire twoIdle = isIdle && idle_q != 2'h0;
    wire [4:0] dec = ephy_dec(grp);
    wire good10  = forceLink10 || linkSeen_q;
    wire ten     = !speed100 && good10;
    wire sqX     = sqPos || sqNeg;
    wire sqOpp   = firstPos_q ? sqNeg : sqPos;
    wire sqOrig  = firstPos_q ? sqPos : sqNeg;
    wire sqWinUp = sqCnt >= 6'(`EPHY_SQWIN_CYC);
    wire rxAct10 = sq_q == SQ_VALID && ten;
    wire hbOff   = fullDuplex || heartbeat_disable;
    wire sqe     = hb_q && !hbOff && hbCnt >= 8'(`EPHY_HBDLY_CYC);
    wire hbEnd   = hbCnt >= 8'(`EPHY_HBDLY_CYC + `EPHY_HBW_CYC);
    wire jabSet  = !jab_q && jabCnt >= 24'(JAB_CYC);
    wire unjab   = jab_q && unjabCnt >= 26'(UNJAB_CYC);
    wire lpWrap  = lpCnt >= 21'(LPPER_CYC - 1);
    wire lpOn    = lpCnt >= 21'(LPPER_CYC - `EPHY_LPW_CYC);
    wire luDone  = sigDetect && luCnt >= 16'(LINKUP_CYC - 1);
    wire crs10   = rxAct10 || (!fullDuplex && ten && txEnMii);
    wire crs100  = pcsOn && (g ? st_d : st_q) != ST_HUNT;
    wire col10   = (ten && !fullDuplex && rxAct10 && txEnMii)
                   || jab_q || (ten && sqe);
    wire badGo   = g && st_q == ST_JCHK && !jkHit;
    wire endData = g && st_q == ST_DATA
                   && (twoIdle || (tSeen_q && grp == `EPHY_R_GRP));

    ephy_align u_align (
        .clk_sys     (clk_sys),
        .rst_b       (rst_b),
        .clkEn       (clkEn),
        .symValid    (symValid && pcsOn),
        .descrBypass (descrBypass),
        .descrBits   (descrBits),
        .rawBits     (rawBits),
        .hunt        (st_q != ST_DATA),
        .grp         (grp),
        .grpValid    (grpValid),
        .jkHit       (jkHit)
    );

    ephy_cnt #(.W(16)) u_luCnt (.clk_sys(clk_sys), .rst_b(rst_b),
        .clkEn(clkEn), .clr(!sigDetect), .count(luCnt));
    ephy_cnt #(.W(21)) u_lpCnt (.clk_sys(clk_sys), .rst_b(rst_b),
        .clkEn(clkEn), .clr(txEnMii || speed100 || lpWrap), .count(lpCnt));
    ephy_cnt #(.W(24)) u_jabCnt (.clk_sys(clk_sys), .rst_b(rst_b),
        .clkEn(clkEn), .clr(!txEnMii || jab_q || speed100),
        .count(jabCnt));
    ephy_cnt #(.W(26)) u_unjabCnt (.clk_sys(clk_sys), .rst_b(rst_b),
        .clkEn(clkEn), .clr(txEnMii || !jab_q), .count(unjabCnt));
    ephy_cnt #(.W(24)) u_lossCnt (.clk_sys(clk_sys), .rst_b(rst_b),
        .clkEn(clkEn), .clr(linkPulseIn), .count(lossCnt));
    ephy_cnt #(.W(6)) u_sqCnt (.clk_sys(clk_sys), .rst_b(rst_b),
        .clkEn(clkEn), .clr(sqClr), .count(sqCnt));
    ephy_cnt #(.W(8)) u_hbCnt (.clk_sys(clk_sys), .rst_b(rst_b),
        .clkEn(clkEn), .clr(!hb_q), .count(hbCnt));

    // 100M receive sequencing
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_HUNT: begin
                if (jkHit) begin
                    st_d = ST_DATA;
                end else if (!isIdle && idle_q == 2'h2) begin
                    st_d = ST_JCHK;
                end
            end
            ST_JCHK: st_d = jkHit ? ST_DATA : ST_BAD;
            ST_DATA: begin
                if (endData) begin
                    st_d = ST_HUNT;
                end
            end
            ST_BAD: begin
                if (twoIdle) begin
                    st_d = ST_HUNT;
                end
            end
            default: st_d = ST_HUNT;
        endcase
    end

    // 10M smart squelch
    always_comb begin
        sq_d  = sq_q;
        sqClr = 1'b0;
        case (sq_q)
            SQ_IDLE: begin
                sqClr = 1'b1;
                if (sqX) begin
                    sq_d = SQ_OPP;
                end
            end
            SQ_OPP: begin
                if (sqOpp) begin
                    sq_d  = SQ_ORIG;
                    sqClr = 1'b1;
                end else if (sqWinUp) begin
                    sq_d = SQ_IDLE;
                end
            end
            SQ_ORIG: begin
                if (sqOrig) begin
                    sq_d  = SQ_VALID;
                    sqClr = 1'b1;
                end else if (sqWinUp) begin
                    sq_d = SQ_IDLE;
                end
            end
            SQ_VALID: begin
                if (sqX) begin
                    sqClr = 1'b1;
                end else if (sqCnt > 6'(`EPHY_SQWIN_CYC)) begin
                    sq_d = SQ_IDLE;
                end
            end
            default: sq_d = SQ_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            st_q    <= ST_HUNT;
            idle_q  <= 2'h0;
            tSeen_q <= 1'b0;
            hold_q  <= 4'h0;
            rxd_q   <= 4'h0;
            rxDv_q  <= 1'b0;
            rxEr_q  <= 1'b0;
        end else if (clkEn) begin
            if (!pcsOn) begin
                st_q   <= ST_HUNT;
                idle_q <= 2'h0;
                rxDv_q <= 1'b0;
                rxEr_q <= 1'b0;
            end else if (g) begin
                st_q    <= st_d;
                idle_q  <= isIdle ? (idle_q == 2'h2 ? 2'h2 : idle_q + 2'h1)
                                  : 2'h0;
                tSeen_q <= st_q == ST_DATA && grp == `EPHY_T_GRP;
                if (st_d == ST_BAD) begin
                    rxd_q  <= `EPHY_BAD_NIB;
                    rxEr_q <= 1'b1;
                    rxDv_q <= 1'b0;
                end else if (st_d == ST_DATA && st_q != ST_DATA) begin
                    rxd_q  <= `EPHY_PRE_NIB;
                    hold_q <= `EPHY_PRE_NIB;
                    rxDv_q <= 1'b1;
                    rxEr_q <= 1'b0;
                end else if (st_d == ST_DATA) begin
                    rxd_q  <= hold_q;
                    rxDv_q <= 1'b1;
                    if (grp != `EPHY_T_GRP) begin
                        hold_q <= dec[3:0];
                        rxEr_q <= dec[4];
                    end
                end else begin
                    rxDv_q <= 1'b0;
                    rxEr_q <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            sq_q       <= SQ_IDLE;
            firstPos_q <= 1'b0;
            fcc_q      <= 16'h0000;
            linkUp_q   <= 1'b0;
            linkSeen_q <= 1'b0;
            jab_q      <= 1'b0;
            hb_q       <= 1'b0;
            txPrev_q   <= 1'b0;
        end else if (clkEn) begin
            sq_q     <= sq_d;
            txPrev_q <= txEnMii;
            linkUp_q <= luDone;
            if (sq_q == SQ_IDLE) begin
                firstPos_q <= sqPos;
            end
            if (badGo) begin
                fcc_q <= fcc_q + 16'h0001;
            end
            if (linkPulseIn) begin
                linkSeen_q <= 1'b1;
            end else if (lossCnt >= 24'(LOSS_CYC)) begin
                linkSeen_q <= 1'b0;
            end
            if (speed100 || unjab) begin
                jab_q <= 1'b0;
            end else if (jabSet) begin
                jab_q <= 1'b1;
            end
            if (txPrev_q && !txEnMii && ten && !hbOff) begin
                hb_q <= 1'b1;
            end else if (hbEnd || hbOff) begin
                hb_q <= 1'b0;
            end
        end
    end

    // outputs other than linkGood10 are registered; linkGood10 is forceLink10 ORed directly with linkSeen_q
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            crs_q    <= 1'b0;
            col_q    <= 1'b0;
            txEn10_q <= 1'b0;
            lpOut_q  <= 1'b0;
        end else if (clkEn) begin
            crs_q    <= speed100 ? crs100 : crs10;
            col_q    <= !speed100 && col10;
            txEn10_q <= ten && txEnMii && !jab_q && !jabSet;
            lpOut_q  <= !speed100 && !txEnMii && lpOn;
        end
    end

    assign rxd                     = rxd_q;
    assign rxDv                    = rxDv_q;
    assign rxEr                    = rxEr_q;
    assign crs                     = crs_q;
    assign col                     = col_q;
    assign linkUp100               = linkUp_q;
    assign linkGood10              = good10;
    assign txEnable10              = txEn10_q;
    assign linkPulseOut            = lpOut_q;
    assign jabber                  = jab_q;
    assign false_carrier_count_reg = fcc_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence s_bad_entry;
        badGo ##1 rxEr_q && rxd_q == `EPHY_BAD_NIB;
    endsequence

    a_fcc_step: assert property (badGo
        |=> fcc_q == $past(fcc_q) + 16'h0001)
        else $error("false carrier count not stepped by one");
    a_bad_err: assert property (badGo |-> s_bad_entry)
        else $error("bad start not flagged on receive");
    a_bad_clear: assert property (g && st_q == ST_BAD && twoIdle
        |=> !rxEr_q && !crs_q)
        else $error("bad start not cleared after two idles");
    a_jk_pre: assert property (g && st_q != ST_DATA && jkHit
        |=> rxDv_q && rxd_q == `EPHY_PRE_NIB && hold_q == `EPHY_PRE_NIB)
        else $error("start pair not replaced by preamble");
    a_link_drop: assert property (clkEn && !sigDetect |=> !linkUp_q)
        else $error("link up without steady signal detect");
    a_fd_nocol: assert property (clkEn && !speed100 && fullDuplex
        && !jab_q && !hb_q |=> !col_q)
        else $error("collision in full duplex");
    a_hd_col: assert property (clkEn && !speed100 && !fullDuplex
        && rxAct10 && txEnMii |=> col_q)
        else $error("half duplex overlap not reported");
    a_jab_col: assert property (clkEn && !speed100 && jab_q
        |=> col_q && !txEn10_q)
        else $error("jabber not reported or transmit not cut");
    a_hb_off: assert property (clkEn && hbOff |=> !hb_q)
        else $error("heartbeat while suppressed");
    a_sq_win: assert property (sq_q == SQ_OPP || sq_q == SQ_ORIG
        |-> sqCnt <= 6'(`EPHY_SQWIN_CYC))
        else $error("squelch window overrun");
endmodule

// file: bench/ephy_mac_model.sv
// MAC side model: drives transmit enable, counts received nibbles
`timescale 1ns/1ps
module ephy_mac_model (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    // bench request
    input  wire logic       txReq,
    // MII
    input  wire logic       rxDv,
    output logic            txEnMii,
    output logic      [7:0] rxCount
);
    logic txReq_q;

    initial begin
        txEnMii = 1'b0;
    end
    // request taken on the rising edge, so no race with the bench
    always @(posedge clk_sys) begin
        txReq_q <= rst_b & txReq;
    end
    always @(negedge clk_sys) begin
        txEnMii <= txReq_q;
    end
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            rxCount <= 8'h00;
        end else if (rxDv === 1'b1) begin
            rxCount <= rxCount + 8'h01;
        end
    end
endmodule

// file: bench/ephy_ctrl_tb.sv
// self-checking bench for the transceiver control block
`timescale 1ns/1ps
`include "ephy_cfg.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module ephy_ctrl_tb;
    logic        clk_sys = 0, rst_b = 0, clkEn = 1, speed100 = 1;
    logic        fullDuplex = 0, heartbeat_disable = 0, forceLink10 = 0;
    logic        descrBypass = 0, sigDetect = 0, symValid = 0, txReq = 0;
    logic        sqPos = 0, sqNeg = 0, linkPulseIn = 0;
    logic [4:0]  descrBits = 5'h00, rawBits = 5'h00;
    logic [3:0]  rxd;
    logic        rxDv, rxEr, crs, col, linkUp100, linkGood10;
    logic        txEnable10, linkPulseOut, jabber, txEnMii;
    logic [15:0] fcCount;
    logic [7:0]  rxCount;
    int          failures = 0, checked = 0, i;

    ephy_ctrl #(.LINKUP_CYC(50), .LPPER_CYC(200), .JAB_CYC(300),
        .UNJAB_CYC(300), .LOSS_CYC(1000)) ephy_ctrl_inst (
        .clk_sys(clk_sys), .rst_b(rst_b), .clkEn(clkEn),
        .speed100(speed100), .fullDuplex(fullDuplex),
        .heartbeat_disable(heartbeat_disable), .forceLink10(forceLink10),
        .descrBypass(descrBypass), .sigDetect(sigDetect),
        .symValid(symValid), .descrBits(descrBits), .rawBits(rawBits),
        .sqPos(sqPos), .sqNeg(sqNeg), .linkPulseIn(linkPulseIn),
        .txEnMii(txEnMii), .rxd(rxd), .rxDv(rxDv), .rxEr(rxEr),
        .crs(crs), .col(col), .linkUp100(linkUp100),
        .linkGood10(linkGood10), .txEnable10(txEnable10),
        .linkPulseOut(linkPulseOut), .jabber(jabber),
        .false_carrier_count_reg(fcCount));
    ephy_mac_model ephy_mac_model_inst (.clk_sys(clk_sys), .rst_b(rst_b),
        .txReq(txReq), .rxDv(rxDv), .txEnMii(txEnMii), .rxCount(rxCount));

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic conclude;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // one symbol; the unused source carries the inverse
    task automatic grp(input logic [4:0] g, input logic [4:0] e,
                       input bit c);
        @(negedge clk_sys);
        if (c) `CHK({rxDv, rxd}, e)
        symValid = 1'b1;
        descrBits = descrBypass ? ~g : g;
        rawBits = descrBypass ? g : ~g;
    endtask

    task automatic sq(input int n);
        for (int k = 0; k < n; k++) begin
            @(negedge clk_sys);
            sqPos = k[1];
            sqNeg = ~k[1];
        end
        sqPos = 1'b0;
        sqNeg = 1'b0;
    endtask

    task automatic t_reset;
        `CHK({crs, col, rxDv, rxEr, jabber, linkGood10}, 6'h00)
        `CHK(fcCount, 16'h0000)
        speed100 = 1'b0;
        i = 0;
        repeat (400) begin
            @(negedge clk_sys);
            i += (linkPulseOut === 1'b1);
        end
        `CHK(i, 20)
        $display("test reset done");
    endtask

    task automatic t_link100;
        speed100 = 1'b1;
        sigDetect = 1'b1;
        cyc(40);
        `CHK(linkUp100, 1'b0)
        for (i = 0; i < 30 && linkUp100 !== 1'b1; i++) cyc(1);
        `CHK(linkUp100, 1'b1)
        if (i == 30) conclude();
        $display("test link100 done");
    endtask

    task automatic t_jk;
        descrBypass = 1'b0;
        repeat (3) grp(`EPHY_IDLE_GRP, 5'h00, 0);
        grp(`EPHY_J_GRP, 5'h00, 0);
        grp(`EPHY_K_GRP, 5'h00, 0);
        grp(5'h0A, 5'h00, 0);
        grp(5'h0E, 5'h00, 0);
        grp(`EPHY_T_GRP, 5'h15, 1);
        grp(`EPHY_R_GRP, 5'h15, 1);
        grp(`EPHY_IDLE_GRP, 5'h14, 1);
        grp(`EPHY_IDLE_GRP, 5'h16, 1);
        repeat (2) grp(`EPHY_IDLE_GRP, 5'h00, 0);
        `CHK(rxDv, 1'b0)
        @(negedge clk_sys);
        symValid = 1'b0;
        `CHK(rxCount, 8'h04)
        $display("test start pair done");
    endtask

    task automatic t_bad;
        descrBypass = 1'b1;
        repeat (3) grp(`EPHY_IDLE_GRP, 5'h00, 0);
        repeat (4) grp(5'h0A, 5'h00, 0);
        grp(5'h0A, 5'h0E, 1);
        `CHK(rxEr, 1'b1)
        `CHK(fcCount, 16'h0001)
        repeat (4) grp(`EPHY_IDLE_GRP, 5'h00, 0);
        @(negedge clk_sys);
        symValid = 1'b0;
        cyc(3);
        `CHK({rxEr, crs}, 2'b00)
        `CHK(fcCount, 16'h0001)
        sigDetect = 1'b0;
        cyc(2);
        `CHK(linkUp100, 1'b0)
        $display("test bad start done");
    endtask

    task automatic t_10m;
        speed100 = 1'b0;
        forceLink10 = 1'b1;
        sqPos = 1'b1;
        cyc(1);
        sqPos = 1'b0;
        cyc(20);
        `CHK({crs, linkGood10}, 2'b01)
        txReq = 1'b1;
        cyc(20);
        `CHK(crs, 1'b1)
        txReq = 1'b0;
        cyc(150);
        `CHK(col, 1'b1)
        cyc(100);
        heartbeat_disable = 1'b1;
        txReq = 1'b1;
        cyc(20);
        txReq = 1'b0;
        cyc(150);
        `CHK(col, 1'b0)
        heartbeat_disable = 1'b0;
        txReq = 1'b1;
        sq(30);
        `CHK(col, 1'b1)
        txReq = 1'b0;
        cyc(30);
        `CHK(crs, 1'b0)
        cyc(250);
        fullDuplex = 1'b1;
        sq(30);
        `CHK(crs, 1'b1)
        txReq = 1'b1;
        sq(10);
        `CHK(col, 1'b0)
        cyc(30);
        `CHK(crs, 1'b0)
        txReq = 1'b0;
        cyc(150);
        `CHK(col, 1'b0)
        $display("test ten meg done");
    endtask

    task automatic t_jabber;
        fullDuplex = 1'b0;
        txReq = 1'b1;
        cyc(310);
        `CHK({jabber, txEnable10}, 2'b10)
        `CHK(col, 1'b1)
        txReq = 1'b0;
        cyc(150);
        `CHK(jabber, 1'b1)
        cyc(170);
        `CHK(jabber, 1'b0)
        $display("test jabber done");
    endtask

    task automatic t_link10;
        forceLink10 = 1'b0;
        txReq = 1'b1;
        cyc(5);
        `CHK({linkGood10, txEnable10, crs}, 3'b000)
        linkPulseIn = 1'b1;
        cyc(1);
        linkPulseIn = 1'b0;
        cyc(2);
        `CHK({linkGood10, txEnable10, crs}, 3'b111)
        txReq = 1'b0;
        cyc(1010);
        `CHK(linkGood10, 1'b0)
        $display("test link ten done");
    endtask

    initial begin
        cyc(12);
        rst_b = 1'b1;
        cyc(1);
        t_reset();
        t_link100();
        t_jk();
        t_bad();
        t_10m();
        t_jabber();
        t_link10();
        conclude();
    end
endmodule
